// ---- rtl/cbr_pkg.sv ----
// Constants and types for the CAN bus-off recovery and interrupt flag block
// What this block does
// - Entering bus-off sets the bus-off flag and the init stop bit, halting CAN.
// - After restart, wait 129 bus idles of 11 recessive bits, then resume, reset counters.
// - Count bus idle occurrences in the receive error counter, readable by software.
// - Each counted bus idle writes 5 into the last error code field.
// - Each such update sets the protocol error flag; an enabled interrupt is requested only if the flag was clear.
// - During recovery the activity state reads synchronising and bus-off stays set.
// - Without dominant bits, restart to bus-off clear takes 1420 bit times.
// - No received message is stored while recovery is in progress.
// - A transmit request during recovery waits until activity reaches idle.
// - Completion clears bus-off and both error counters; idle follows one bit later.
// - Idle lasts one bit at least; then receiver on dominant, transmitter on pending request.
// - A hardware set and software clear in one cycle leave the flag set.
// - An interrupt request comes only from a zero-to-one flag transition.
// - Set-wins applies to all flags except the receive timeout event flag.
// - Reception writes only the bytes the length code covers; the rest keep old data.
package cbr_pkg;
  // -------------------------------------------------------------------
  // Register map (byte offsets)
  // -------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_ERRCNT = 5'h08;
  localparam logic [4:0] OFS_FLAGS = 5'h0c;
  localparam logic [4:0] OFS_IRQ_EN = 5'h10;
  localparam logic [4:0] OFS_RXBUF0 = 5'h14;
  localparam logic [4:0] OFS_RXBUF1 = 5'h18;
  // Field positions
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_TXREQ_BIT = 1;
  localparam int FLAG_PEA_BIT = 0;
  localparam int FLAG_RXNEW_BIT = 1;
  localparam int FLAG_TOUT_BIT = 2;
  localparam int NUM_FLAGS = 3;
  // Reset values
  localparam logic RST_INIT = 1'b1;
  localparam logic [NUM_FLAGS-1:0] RST_IRQ_EN = 3'h0;
  // Protocol figures
  localparam logic [3:0] IDLE_RUN_BITS = 4'hb;
  localparam logic [7:0] IDLE_OCCURRENCES = 8'h81;
  localparam logic [2:0] LEC_RECESSIVE_SEEN_DOMINANT = 3'h5;
  localparam logic [7:0] ERR_CNT_MAX = 8'hff;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = (BIT_TIME_NS * CLK_MHZ + 999) / 1000;
  // -------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_SYNC,
    ACT_IDLE,
    ACT_RX,
    ACT_TX
  } cbr_act_t;
  typedef enum logic [1:0] {
    REC_RUN,
    REC_HALT,
    REC_WAIT,
    REC_TAIL
  } cbr_rec_t;
  typedef struct packed {
    logic [3:0] dlc;
    logic [63:0] data;
  } cbr_rx_frame_t;
endpackage

// ---- rtl/cbr_busoff_ctrl.sv ----
// CAN bus-off recovery sequencer, interrupt flags and receive buffer with Avalon-MM slave
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cbr_busoff_ctrl #(
  parameter int BIT_CYCLES = cbr_pkg::BIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic can_rx_i,
  input wire logic busoff_entry_i,
  input wire logic tec_inc_i,
  input wire logic rec_inc_i,
  input wire logic frame_done_i,
  input wire logic rx_store_i,
  input wire cbr_pkg::cbr_rx_frame_t rx_frame_i,
  input wire logic rx_timeout_i,
  output logic tx_start_o,
  output logic irq_o,
  output logic bus_off_o,
  output cbr_pkg::cbr_act_t activity_o
);
  import cbr_pkg::*;

  // -------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle on every access
  // -------------------------------------------------------------------
  logic wait_r;
  logic [31:0] rdata_nxt;
  logic [31:0] wmask;
  logic wr_en;
  logic [31:0] wdata;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wr_en = avs_write_i && !wait_r;
  assign wdata = avs_writedata_i & wmask;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((avs_read_i || avs_write_i) && wait_r);
    end
  end
  assign avs_waitrequest_o = wait_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && wait_r) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

  // -------------------------------------------------------------------
  // Bit time divider
  // -------------------------------------------------------------------
  logic [$clog2(BIT_CYCLES+1)-1:0] div_r;
  logic tick_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == $bits(div_r)'(BIT_CYCLES - 1));
      div_r <= (div_r == $bits(div_r)'(BIT_CYCLES - 1)) ? '0 : div_r + 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Recovery sequencer
  // -------------------------------------------------------------------
  cbr_rec_t rec_st_r;
  logic init_r;
  logic bus_off_r;
  logic [3:0] run_r;
  logic [7:0] rec_cnt_r;
  logic [7:0] tec_cnt_r;
  logic [2:0] lec_r;
  logic occur;
  logic done;
  logic busoff_set;
  assign busoff_set = busoff_entry_i && rec_st_r == REC_RUN;
  assign occur = rec_st_r == REC_WAIT && tick_r && can_rx_i && run_r == IDLE_RUN_BITS - 4'h1;
  assign done = rec_st_r == REC_TAIL && tick_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rec_st_r <= REC_RUN;
    end else begin
      unique case (rec_st_r)
        REC_RUN: if (busoff_set) rec_st_r <= REC_HALT;
        REC_HALT: if (!init_r) rec_st_r <= REC_WAIT;
        REC_WAIT: if (occur && rec_cnt_r == IDLE_OCCURRENCES - 8'h1) rec_st_r <= REC_TAIL;
        REC_TAIL: if (tick_r) rec_st_r <= REC_RUN;
      endcase
    end
  end

  // Hardware set beats a software clear of the stop bit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      init_r <= RST_INIT;
    end else if (busoff_set) begin
      init_r <= 1'b1;
    end else if (wr_en && avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
      init_r <= avs_writedata_i[CTRL_INIT_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_off_r <= 1'b0;
    end else if (busoff_set) begin
      bus_off_r <= 1'b1;
    end else if (done) begin
      bus_off_r <= 1'b0;
    end
  end
  assign bus_off_o = bus_off_r;

  // Recessive run length; a dominant bit restarts the run only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_r <= 4'h0;
    end else if (rec_st_r != REC_WAIT || occur) begin
      run_r <= 4'h0;
    end else if (tick_r) begin
      run_r <= can_rx_i ? run_r + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rec_cnt_r <= 8'h0;
      tec_cnt_r <= 8'h0;
    end else if (done) begin
      rec_cnt_r <= 8'h0;
      tec_cnt_r <= 8'h0;
    end else if (rec_st_r == REC_HALT && !init_r) begin
      // Leftover receive errors would shorten the 129-idle wait
      rec_cnt_r <= 8'h0;
    end else if (rec_st_r == REC_WAIT) begin
      if (occur) rec_cnt_r <= rec_cnt_r + 8'h1;
    end else if (rec_st_r == REC_RUN && !busoff_set) begin
      if (rec_inc_i && rec_cnt_r != ERR_CNT_MAX) rec_cnt_r <= rec_cnt_r + 8'h1;
      if (tec_inc_i && tec_cnt_r != ERR_CNT_MAX) tec_cnt_r <= tec_cnt_r + 8'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lec_r <= 3'h0;
    end else if (occur) begin
      lec_r <= LEC_RECESSIVE_SEEN_DOMINANT;
    end
  end

  // -------------------------------------------------------------------
  // Activity state and transmit start
  // -------------------------------------------------------------------
  cbr_act_t act_r;
  logic idle_aged_r;
  logic tx_pend_r;
  logic tx_req_wr;
  logic running;
  assign running = rec_st_r == REC_RUN && !init_r && !busoff_set;
  assign tx_req_wr = wr_en && avs_address_i == OFS_CTRL && avs_byteenable_i[0] &&
                     avs_writedata_i[CTRL_TXREQ_BIT];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_r <= ACT_SYNC;
      idle_aged_r <= 1'b0;
      tx_start_o <= 1'b0;
    end else begin
      tx_start_o <= 1'b0;
      if (!running) begin
        act_r <= ACT_SYNC;
        idle_aged_r <= 1'b0;
      end else begin
        unique case (act_r)
          ACT_SYNC: if (tick_r) act_r <= ACT_IDLE;
          ACT_IDLE: if (tick_r) begin
            idle_aged_r <= 1'b1;
            if (idle_aged_r && !can_rx_i) begin
              act_r <= ACT_RX;
            end else if (idle_aged_r && tx_pend_r) begin
              act_r <= ACT_TX;
              tx_start_o <= 1'b1;
            end
          end
          ACT_RX, ACT_TX: if (frame_done_i) begin
            act_r <= ACT_IDLE;
            idle_aged_r <= 1'b0;
          end
        endcase
      end
    end
  end
  assign activity_o = act_r;

  // Request stays pending through recovery; a new write beats the start
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_pend_r <= 1'b0;
    end else if (tx_req_wr) begin
      tx_pend_r <= 1'b1;
    end else if (tx_start_o) begin
      tx_pend_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Receive buffer: only the bytes the length code covers are written
  // -------------------------------------------------------------------
  logic [7:0] rxbuf_r [8];
  logic store_en;
  assign store_en = rx_store_i && running && !bus_off_r;

  for (genvar i = 0; i < 8; i++) begin : g_rxbyte
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        rxbuf_r[i] <= 8'h0;
      end else if (store_en && 4'(i) < rx_frame_i.dlc) begin
        rxbuf_r[i] <= rx_frame_i.data[8*i +: 8];
      end
    end
  end

  // -------------------------------------------------------------------
  // Interrupt flags, enables and request pulse
  // -------------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flag_r;
  logic [NUM_FLAGS-1:0] flag_nxt;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] irq_en_r;
  assign flag_set = {rx_timeout_i, store_en, occur};
  assign flag_clr = (wr_en && avs_address_i == OFS_FLAGS) ?
                    wdata[NUM_FLAGS-1:0] : '0;

  always_comb begin
    flag_nxt = (flag_r & ~flag_clr) | flag_set;
    // Timeout event flag lets the clear win
    if (flag_clr[FLAG_TOUT_BIT]) flag_nxt[FLAG_TOUT_BIT] = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_r <= '0;
      irq_o <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_o <= |(flag_nxt & ~flag_r & irq_en_r);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_en_r <= RST_IRQ_EN;
    end else if (wr_en && avs_address_i == OFS_IRQ_EN && avs_byteenable_i[0]) begin
      irq_en_r <= avs_writedata_i[NUM_FLAGS-1:0];
    end
  end

  // -------------------------------------------------------------------
  // Read mux; unmapped offsets read zero
  // -------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0;
    unique case (avs_address_i)
      OFS_CTRL: rdata_nxt = {30'h0, tx_pend_r, init_r};
      OFS_STATUS: rdata_nxt = {26'h0, bus_off_r, act_r, lec_r};
      OFS_ERRCNT: rdata_nxt = {16'h0, rec_cnt_r, tec_cnt_r};
      OFS_FLAGS: rdata_nxt = {29'h0, flag_r};
      OFS_IRQ_EN: rdata_nxt = {29'h0, irq_en_r};
      OFS_RXBUF0: rdata_nxt = {rxbuf_r[3], rxbuf_r[2], rxbuf_r[1], rxbuf_r[0]};
      OFS_RXBUF1: rdata_nxt = {rxbuf_r[7], rxbuf_r[6], rxbuf_r[5], rxbuf_r[4]};
      default: rdata_nxt = 32'h0;
    endcase
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  busoff_halt_a: assert property (
    busoff_set |=> init_r && bus_off_r && rec_st_r == REC_HALT)
    else $error("bus-off entry did not halt");
  halt_hold_a: assert property (
    rec_st_r == REC_HALT && init_r |=> rec_st_r == REC_HALT && bus_off_r)
    else $error("left bus-off without software");
  tail_count_a: assert property (
    $rose(rec_st_r == REC_TAIL) |-> rec_cnt_r == IDLE_OCCURRENCES)
    else $error("recovery ended with wrong idle count");
  idle_count_a: assert property (
    occur |=> rec_cnt_r == $past(rec_cnt_r) + 8'h1)
    else $error("idle occurrence not counted");
  lec_flag_a: assert property (
    occur |=> lec_r == LEC_RECESSIVE_SEEN_DOMINANT && flag_r[FLAG_PEA_BIT])
    else $error("idle occurrence not flagged");
  pea_irq_a: assert property (
    occur && !flag_r[FLAG_PEA_BIT] && irq_en_r[FLAG_PEA_BIT] |=> irq_o)
    else $error("protocol error request missing");
  sync_report_a: assert property (
    rec_st_r == REC_WAIT |-> act_r == ACT_SYNC && bus_off_r)
    else $error("activity not synchronising in recovery");
  no_store_a: assert property (
    bus_off_r |=> $stable(rxbuf_r[0]) && !$rose(flag_r[FLAG_RXNEW_BIT]))
    else $error("frame stored during recovery");
  tx_hold_a: assert property (
    tx_start_o |-> act_r == ACT_TX && $past(act_r) == ACT_IDLE && !bus_off_r)
    else $error("transmit started outside idle");
  clear_done_a: assert property (
    $fell(bus_off_r) |-> rec_cnt_r == 8'h0 && tec_cnt_r == 8'h0 && act_r == ACT_SYNC)
    else $error("counters not cleared at completion");
  idle_min_a: assert property (
    $rose(act_r == ACT_IDLE) |=> act_r == ACT_IDLE)
    else $error("idle left too early");
  set_wins_a: assert property (
    flag_set[FLAG_PEA_BIT] && flag_clr[FLAG_PEA_BIT] |=> flag_r[FLAG_PEA_BIT])
    else $error("clear beat a set");
  irq_edge_a: assert property (
    irq_o |-> |(flag_r & ~$past(flag_r) & $past(irq_en_r)))
    else $error("request without flag rise");
  tout_clear_a: assert property (
    flag_clr[FLAG_TOUT_BIT] |=> !flag_r[FLAG_TOUT_BIT])
    else $error("timeout flag clear lost");
  keep_bytes_a: assert property (
    store_en && rx_frame_i.dlc < 4'h8 |=> $stable(rxbuf_r[7]))
    else $error("byte beyond length written");
  run_restart_a: assert property (
    rec_st_r == REC_WAIT && tick_r && !can_rx_i |=> run_r == 4'h0 && $stable(rec_cnt_r))
    else $error("dominant bit did not restart run");
endmodule // cbr_busoff_ctrl
`default_nettype wire

// ---- tb/cbr_can_node_model.sv ----
// Model of the other CAN nodes: bus recessive at rest, dominant bits on command
`timescale 1ns/1ps
`default_nettype none
module cbr_can_node_model #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic dom_req_i,
  output logic can_rx_o
);
  int cnt_r;
  // -------------------------------------------------------------------
  // Bit driver
  // -------------------------------------------------------------------
  // One request holds the bus dominant for exactly one bit time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 0;
    end else if (dom_req_i) begin
      cnt_r <= BIT_CYCLES;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
    end
  end
  assign can_rx_o = (cnt_r == 0);
endmodule // cbr_can_node_model
`default_nettype wire

// ---- tb/cbr_busoff_ctrl_tb.sv ----
// Self-checking bench for the CAN bus-off recovery and interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; $display("[FAIL] %0t %s", $time, msg); end end
module cbr_busoff_ctrl_tb;
  import cbr_pkg::*;
  localparam int BC = 4;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic dom_req = 1'b0;
  logic [5:0] pv = 6'h00;
  logic [1:0] coll = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rv;
  cbr_rx_frame_t frame = '0;
  logic wreq;
  logic tx_start;
  logic irq;
  logic bus_off;
  logic can_rx;
  cbr_act_t act;
  // Collisions land a hardware set on the very edge that the clear takes effect
  wire logic win = wr & ~wreq;
  wire logic store_w = pv[4] | (coll[0] & win);
  wire logic tout_w = pv[5] | (coll[1] & win);
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_irq = 0;
  int n_tx = 0;
  int t_tx = 0;
  int tx0 = 0;

  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  // Pulses are counted off the edge so no race with their launch
  always @(negedge clk_i) begin
    if (irq === 1'b1) n_irq <= n_irq + 1;
    if (tx_start === 1'b1) begin
      n_tx <= n_tx + 1;
      t_tx <= cyc;
    end
  end

  cbr_busoff_ctrl #(.BIT_CYCLES(BC)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .can_rx_i(can_rx),
    .busoff_entry_i(pv[0]), .tec_inc_i(pv[1]), .rec_inc_i(pv[2]), .frame_done_i(pv[3]),
    .rx_store_i(store_w), .rx_frame_i(frame), .rx_timeout_i(tout_w),
    .tx_start_o(tx_start), .irq_o(irq), .bus_off_o(bus_off), .activity_o(act)
  );
  cbr_can_node_model #(.BIT_CYCLES(BC)) bus_model (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .dom_req_i(dom_req), .can_rx_o(can_rx)
  );

  task automatic tally_and_finish();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (wreq === 1'b0) break;
    end
    if (i == 50) begin
      n_fail++;
      tally_and_finish();
    end
    if (!w) rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge clk_i);
    pv[b] <= 1'b1;
    @(posedge clk_i);
    pv[b] <= 1'b0;
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: return bus_off === 1'b0;
      1: return act === ACT_IDLE;
      2: return n_tx != tx0;
      default: return act === ACT_RX;
    endcase
  endfunction
  task automatic wait_for(input int s, input int lim);
    int i;
    for (i = 0; i < lim && !cond(s); i++) @(negedge clk_i);
    if (!cond(s)) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    @(negedge clk_i);
    `CHK(bus_off, 1'b0, "bus-off after reset")
    `CHK(act, ACT_SYNC, "activity after reset")
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK(rv[CTRL_INIT_BIT], RST_INIT, "stop bit after reset")
    bus(1'b0, 5'h1c, 32'h0);
    `CHK(rv, 32'h0, "unmapped read")
  endtask

  task automatic t_flags();
    int i;
    int n0;
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_IRQ_EN, 32'h7);
    n0 = n_irq;
    frame <= '{dlc: 4'h8, data: 64'haaaa_aaaa_aaaa_aaaa};
    pulse(4);
    frame <= '{dlc: 4'h3, data: 64'h5555_5555_5544_3322};
    pulse(4);
    bus(1'b0, OFS_RXBUF0, 32'h0);
    `CHK(rv, 32'haa44_3322, "rx low word")
    `CHK(rv[23:0], 24'h44_3322, "valid bytes per length code")
    bus(1'b0, OFS_RXBUF1, 32'h0);
    `CHK(rv, 32'haaaa_aaaa, "rx high word kept")
    `CHK(n_irq - n0, 1, "one request per flag rise")
    coll <= 2'h1;
    bus(1'b1, OFS_FLAGS, 32'h2);
    coll <= 2'h0;
    bus(1'b0, OFS_FLAGS, 32'h0);
    `CHK(rv[FLAG_RXNEW_BIT], 1'b1, "set must beat clear")
    `CHK(n_irq - n0, 1, "no request while flag stays set")
    for (i = 0; i < 4 && rv[FLAG_RXNEW_BIT] !== 1'b0; i++) begin
      bus(1'b1, OFS_FLAGS, 32'h2);
      bus(1'b0, OFS_FLAGS, 32'h0);
    end
    `CHK(rv[FLAG_RXNEW_BIT], 1'b0, "flag cleared after retry")
    pulse(5);
    coll <= 2'h2;
    bus(1'b1, OFS_FLAGS, 32'h4);
    coll <= 2'h0;
    bus(1'b0, OFS_FLAGS, 32'h0);
    `CHK(rv[FLAG_TOUT_BIT], 1'b0, "timeout clear must win")
  endtask

  task automatic t_busoff();
    int n0;
    int t0;
    int t1;
    int ta;
    pulse(1);
    pulse(1);
    pulse(2);
    bus(1'b0, OFS_ERRCNT, 32'h0);
    `CHK(rv[15:0], 16'h0102, "error counters")
    pulse(0);
    repeat (2) @(negedge clk_i);
    `CHK(bus_off, 1'b1, "bus-off entry")
    `CHK(act, ACT_SYNC, "halted activity")
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK(rv[CTRL_INIT_BIT], 1'b1, "stop bit set by bus-off")
    bus(1'b1, OFS_CTRL, 32'h3);
    bus(1'b1, OFS_FLAGS, 32'h7);
    frame <= '{dlc: 4'h8, data: 64'h0};
    pulse(4);
    bus(1'b0, OFS_RXBUF0, 32'h0);
    `CHK(rv, 32'haa44_3322, "no store in bus-off")
    bus(1'b0, OFS_FLAGS, 32'h0);
    `CHK(rv[FLAG_RXNEW_BIT], 1'b0, "no rx flag in bus-off")
    repeat (40 * BC) @(posedge clk_i);
    `CHK(bus_off, 1'b1, "bus-off held until restart")
    n0 = n_irq;
    tx0 = n_tx;
    bus(1'b1, OFS_CTRL, 32'h0);
    t0 = cyc;
    // Break the first recessive run; idle count must survive it
    repeat (5 * BC) @(posedge clk_i);
    dom_req <= 1'b1;
    @(posedge clk_i);
    dom_req <= 1'b0;
    repeat (16 * BC) @(posedge clk_i);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(rv[2:0], LEC_RECESSIVE_SEEN_DOMINANT, "error code per idle")
    `CHK(rv[5:3], 3'h4, "sync with bus-off held")
    bus(1'b0, OFS_ERRCNT, 32'h0);
    `CHK(rv[15:8], 8'h01, "idle count in rx counter")
    bus(1'b0, OFS_FLAGS, 32'h0);
    `CHK(rv[FLAG_PEA_BIT], 1'b1, "protocol error flag")
    wait_for(0, 1500 * BC);
    t1 = cyc;
    `CHK((t1 - t0 >= 1424 * BC) && (t1 - t0 <= 1428 * BC + 4), 1'b1, "recovery time")
    `CHK(act, ACT_SYNC, "idle comes a bit later")
    `CHK(n_tx, tx0, "no transmit during recovery")
    `CHK(n_irq - n0, 1, "single request for held flag")
    wait_for(1, 4 * BC);
    ta = cyc;
    `CHK((ta - t1 >= BC - 3) && (ta - t1 <= BC + 3), 1'b1, "idle one bit after")
    bus(1'b0, OFS_ERRCNT, 32'h0);
    `CHK(rv[15:0], 16'h0000, "counters cleared")
    wait_for(2, 20 * BC);
    `CHK(t_tx - ta >= BC - 1, 1'b1, "idle held one bit")
    @(negedge clk_i);
    `CHK(act, ACT_TX, "transmitter state")
    pulse(3);
    wait_for(1, 4 * BC);
    repeat (2 * BC) @(posedge clk_i);
    dom_req <= 1'b1;
    @(posedge clk_i);
    dom_req <= 1'b0;
    wait_for(3, 10 * BC);
    `CHK(act, ACT_RX, "receiver on dominant")
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_flags();
    t_busoff();
    tally_and_finish();
  end
endmodule // cbr_busoff_ctrl_tb
`default_nettype wire
